// >>> rtl/iols_pkg.sv
// Package for the I/O window top and downstream bus status block.
// Assumes a byte-wide configuration access port from the bridge core.
package iols_pkg;

  // Configuration offsets
  localparam logic [7:0] OFS_IO_WINDOW_BOTTOM   = 8'h1c;
  localparam logic [7:0] OFS_IO_WINDOW_TOP      = 8'h1d;
  localparam logic [7:0] OFS_BUS_STATUS_LO      = 8'h1e;
  localparam logic [7:0] OFS_BUS_STATUS_HI      = 8'h1f;
  localparam logic [7:0] OFS_IO_BOTTOM_UPPER    = 8'h30;
  localparam logic [7:0] OFS_IO_TOP_UPPER       = 8'h32;

  // Window field layout
  localparam int         IO_FIELD_MSB           = 7;
  localparam int         IO_FIELD_LSB           = 4;
  localparam logic [3:0] IO_ADDR_WIDTH_CODE     = 4'h1;
  localparam logic [7:0] IO_WINDOW_TOP_RESET    = 8'h01;
  localparam logic [7:0] IO_WINDOW_BOTTOM_RESET = 8'h01;
  localparam logic [11:0] IO_TOP_LOW_FILL       = 12'hfff;
  localparam logic [11:0] IO_BOTTOM_LOW_FILL    = 12'h000;

  // Status bit positions
  localparam int BIT_PARITY_FAULT  = 15;
  localparam int BIT_SYSTEM_FAULT  = 14;
  localparam int BIT_MASTER_ABORT  = 13;
  localparam int BIT_TARGET_ABORT  = 12;
  localparam int BIT_FAST_CLOCK    = 5;
  localparam logic [1:0] DECODE_SPEED_MEDIUM = 2'h1;
  localparam logic       FAST_B2B_CAPABLE    = 1'b1;

  // Pin synchroniser depth
  localparam int SYNC_STAGES = 3;

  // Secondary bus events, one pulse each per cycle
  typedef struct packed {
    logic addr_attr_error;  // Address or attribute error as target
    logic write_data_error; // Data error as write target
    logic read_data_error;  // Data error as read master
    logic system_error;     // System error seen
    logic master_abort;     // Our master transaction aborted
    logic target_abort;     // Target abort received
  } iols_event_t;

  // Configuration access
  typedef struct packed {
    logic       rd;     // Read strobe
    logic       wr;     // Write strobe
    logic [7:0] addr;   // Byte offset
    logic [7:0] wdata;  // Write byte
  } iols_cfg_req_t;

endpackage

// >>> rtl/iols_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes the pin is asynchronous to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
module iols_pin_sync
  import iols_pkg::*;
(
  input  wire logic sys_clk_i, // System clock
  input  wire logic rst_i,     // Sync reset, high
  input  wire logic ce_i,      // Clock enable
  input  wire logic pin_i,     // Raw pin
  output logic      level_o    // Filtered level
);

  logic [SYNC_STAGES-1:0] stage_ff; // Shift chain
  logic                   level_ff; // Accepted level

  // Chain; first stage feeds only the second
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      stage_ff <= '0;
    else if (ce_i)
      stage_ff <= {stage_ff[SYNC_STAGES-2:0], pin_i};
  end

  // Accept a change once stages two and three agree
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      level_ff <= 1'b0;
    else if (ce_i && (stage_ff[1] == stage_ff[2]))
      level_ff <= stage_ff[2];
  end

  assign level_o = level_ff;

endmodule
`default_nettype wire

// >>> rtl/iols_regs.sv
// I/O window top register, downstream bus status register and the
// I/O window compare of the bridge configuration space.
// Assumes single-byte config accesses from the bridge core.
// Operation
// - I/O window top register at 1Dh
// - Bits 7:4 give address bits 15:12
// - Low twelve top bits read as FFFh
// - Top bits 31:16 from register 32h
// - Bits 3:0 read 1h; reset 01h
// - Bottom low bits zero; forward within range
// - Sixteen-bit status register at 1Eh
// - Status resets to 02X0h
// - Bit 15 on address/attribute error
// - Bit 15 on write/read data error
// - Parity bit ignores parity response enable
// - Bit 14 on system error seen
// - Bit 13 on our master abort
// - Bit 12 on received target abort
// - Bits 10:9 read 01b
// - Bit 5 follows fast clock pin
`timescale 1ns/1ps
`default_nettype none
module iols_regs
  import iols_pkg::*;
(
  input  wire logic          sys_clk_i,      // 40 MHz clock
  input  wire logic          rst_i,          // Sync reset, high
  input  wire logic          ce_i,           // Clock enable
  input  wire iols_cfg_req_t cfg_req_i,      // Config access
  output logic [7:0]         cfg_rdata_o,    // Read byte
  output logic               cfg_hit_o,      // Offset is ours
  input  wire iols_event_t   bus_event_i,    // Secondary events
  input  wire logic          parity_response_enable_i, // Unused gate
  input  wire logic          fast_clock_pin_i,   // Pin, async
  input  wire logic [31:0]   io_addr_i,      // I/O address probe
  output logic               io_forward_o,   // Address inside window
  output logic [31:0]        io_window_top_o // Window top address
);

  logic [3:0]  io_window_top_field_ff;    // Top bits 15:12
  logic [3:0]  io_window_bottom_field_ff; // Bottom bits 15:12
  logic [15:0] io_top_upper_ff;           // Top bits 31:16
  logic [15:0] io_bottom_upper_ff;        // Bottom bits 31:16
  logic        parity_fault_seen_ff;      // Status bit 15
  logic        system_fault_seen_ff;      // Status bit 14
  logic        master_abort_seen_ff;      // Status bit 13
  logic        target_abort_received_ff;  // Status bit 12
  logic        fast_clock_capable;        // Synchronised pin
  logic [15:0] bus_status;                // Assembled status
  logic [31:0] io_window_bottom;          // Window bottom address
  logic [7:0]  nxt_rdata;                 // Read mux
  logic        nxt_hit;                   // Decode
  logic        clr_hi;                    // W1C high byte
  logic        parity_event;              // Any parity event

  // Fast clock pin crosses in through its own filter
  // Bit 5 lags a pin change by about four edges
  iols_pin_sync u_fast_clk_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .pin_i     (fast_clock_pin_i),
    .level_o   (fast_clock_capable)
  );

  // Write decode for one offset
  function automatic logic wr_at(input iols_cfg_req_t r,
                                 input logic [7:0] ofs);
    wr_at = r.wr && (r.addr == ofs);
  endfunction

  // Forms a 32-bit window address from upper, field and fill
  function automatic logic [31:0] win_addr(input logic [15:0] up,
                                           input logic [3:0] fld,
                                           input logic [11:0] fill);
    win_addr = {up, fld, fill};
  endfunction

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      io_window_top_field_ff <= IO_WINDOW_TOP_RESET[7:4];
    // Only the upper nibble takes the write
    else if (ce_i && wr_at(cfg_req_i, OFS_IO_WINDOW_TOP))
      io_window_top_field_ff <=
        cfg_req_i.wdata[IO_FIELD_MSB:IO_FIELD_LSB];
  end

  // Bottom field, kept here for the window compare
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      io_window_bottom_field_ff <= IO_WINDOW_BOTTOM_RESET[7:4];
    // Low nibble stays the fixed width code
    else if (ce_i && wr_at(cfg_req_i, OFS_IO_WINDOW_BOTTOM))
      io_window_bottom_field_ff <=
        cfg_req_i.wdata[IO_FIELD_MSB:IO_FIELD_LSB];
  end

  // upper sixteen top bits, written a byte at a time
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      io_top_upper_ff <= 16'h0000;
    else if (ce_i)
    begin
      // Low byte at the base offset
      if (wr_at(cfg_req_i, OFS_IO_TOP_UPPER))
        io_top_upper_ff[7:0] <= cfg_req_i.wdata;
      // High byte one offset up
      if (wr_at(cfg_req_i, OFS_IO_TOP_UPPER + 8'h01))
        io_top_upper_ff[15:8] <= cfg_req_i.wdata;
    end
  end

  // Upper sixteen bottom bits
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      io_bottom_upper_ff <= 16'h0000;
    else if (ce_i)
    begin
      // Low byte at the base offset
      if (wr_at(cfg_req_i, OFS_IO_BOTTOM_UPPER))
        io_bottom_upper_ff[7:0] <= cfg_req_i.wdata;
      // High byte one offset up
      if (wr_at(cfg_req_i, OFS_IO_BOTTOM_UPPER + 8'h01))
        io_bottom_upper_ff[15:8] <= cfg_req_i.wdata;
    end
  end

  // Clear strobe for the status high byte only
  always_comb
  begin
    // Low byte holds no clearable bits, so no strobe
    clr_hi = ce_i && wr_at(cfg_req_i, OFS_BUS_STATUS_HI);
  end

  // address/attribute, write data or read data error
  // parity response enable deliberately not used
  assign parity_event = bus_event_i.addr_attr_error
                      | bus_event_i.write_data_error
                      | bus_event_i.read_data_error;

  // event set wins over the software clear
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      parity_fault_seen_ff <= 1'b0;
    else if (ce_i)
    begin
      // New event sets, even against a clear
      if (parity_event)
        parity_fault_seen_ff <= 1'b1;
      // Write one to bit 15 clears
      else if (clr_hi && cfg_req_i.wdata[BIT_PARITY_FAULT-8])
        parity_fault_seen_ff <= 1'b0;
    end
  end

  // system error seen on the secondary bus
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      system_fault_seen_ff <= 1'b0;
    else if (ce_i)
    begin
      // New event sets, even against a clear
      if (bus_event_i.system_error)
        system_fault_seen_ff <= 1'b1;
      // Write one to bit 14 clears
      else if (clr_hi && cfg_req_i.wdata[BIT_SYSTEM_FAULT-8])
        system_fault_seen_ff <= 1'b0;
    end
  end

  // master abort on our own transaction
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      master_abort_seen_ff <= 1'b0;
    else if (ce_i)
    begin
      // New event sets, even against a clear
      if (bus_event_i.master_abort)
        master_abort_seen_ff <= 1'b1;
      // Write one to bit 13 clears
      else if (clr_hi && cfg_req_i.wdata[BIT_MASTER_ABORT-8])
        master_abort_seen_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      target_abort_received_ff <= 1'b0;
    else if (ce_i)
    begin
      // New event sets, even against a clear
      if (bus_event_i.target_abort)
        target_abort_received_ff <= 1'b1;
      // Write one to bit 12 clears
      else if (clr_hi && cfg_req_i.wdata[BIT_TARGET_ABORT-8])
        target_abort_received_ff <= 1'b0;
    end
  end

  // status assembly; unlisted bits read zero
  // fast clock bit from the filtered pin
  // reset view 02X0h follows from the above
  always_comb
  begin
    bus_status                   = 16'h0000;
    bus_status[BIT_PARITY_FAULT] = parity_fault_seen_ff;
    bus_status[BIT_SYSTEM_FAULT] = system_fault_seen_ff;
    bus_status[BIT_MASTER_ABORT] = master_abort_seen_ff;
    bus_status[BIT_TARGET_ABORT] = target_abort_received_ff;
    bus_status[10:9]             = DECODE_SPEED_MEDIUM;
    bus_status[7]                = FAST_B2B_CAPABLE;
    bus_status[BIT_FAST_CLOCK]   = fast_clock_capable;
  end

  // Read mux; low bits of the top register are a constant
  always_comb
  begin
    nxt_rdata = 8'h00;
    nxt_hit   = 1'b1;
    unique case (cfg_req_i.addr)
      // width code constant in bits 3:0
      OFS_IO_WINDOW_TOP:
        nxt_rdata = {io_window_top_field_ff, IO_ADDR_WIDTH_CODE};
      // Bottom shares the same width code
      OFS_IO_WINDOW_BOTTOM:
        nxt_rdata = {io_window_bottom_field_ff, IO_ADDR_WIDTH_CODE};
      // Status low byte: fixed bits and pin
      OFS_BUS_STATUS_LO:
        nxt_rdata = bus_status[7:0];
      // Status high byte: event flags, speed
      OFS_BUS_STATUS_HI:
        nxt_rdata = bus_status[15:8];
      // Top upper, low byte
      OFS_IO_TOP_UPPER:
        nxt_rdata = io_top_upper_ff[7:0];
      // Top upper, high byte
      OFS_IO_TOP_UPPER + 8'h01:
        nxt_rdata = io_top_upper_ff[15:8];
      // Bottom upper, low byte
      OFS_IO_BOTTOM_UPPER:
        nxt_rdata = io_bottom_upper_ff[7:0];
      // Bottom upper, high byte
      OFS_IO_BOTTOM_UPPER + 8'h01:
        nxt_rdata = io_bottom_upper_ff[15:8];
      // Not ours: zero data, no hit
      default:
        nxt_hit = 1'b0;
    endcase
  end

  // Registered read data, one cycle after the strobe
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      cfg_rdata_o <= 8'h00;
      cfg_hit_o   <= 1'b0;
    end
    // Idle cycles return zero and no hit
    else if (ce_i)
    begin
      cfg_rdata_o <= cfg_req_i.rd ? nxt_rdata : 8'h00;
      cfg_hit_o   <= cfg_req_i.rd && nxt_hit;
    end
  end

  // top fills low twelve bits with ones
  always_comb
  begin
    io_window_top_o  = win_addr(io_top_upper_ff,
                                io_window_top_field_ff,
                                IO_TOP_LOW_FILL);
    io_window_bottom = win_addr(io_bottom_upper_ff,
                                io_window_bottom_field_ff,
                                IO_BOTTOM_LOW_FILL);
  end

  // inclusive range compare, registered
  // Costs a cycle of latency but keeps the output a flop
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      io_forward_o <= 1'b0;
    else if (ce_i)
      io_forward_o <= (io_addr_i >= io_window_bottom)
                   && (io_addr_i <= io_window_top_o);
  end

endmodule
`default_nettype wire

// >>> sim/iols_regs_props.sv
// Port assertions for the window top and bus status registers.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module iols_regs_props
  import iols_pkg::*;
(
  input wire logic          sys_clk_i,      // Clock
  input wire logic          rst_i,          // Reset, high
  input wire logic          ce_i,           // Clock enable
  input wire iols_cfg_req_t cfg_req_i,      // Config access
  input wire logic [7:0]    cfg_rdata_o,    // Read byte
  input wire logic          cfg_hit_o,      // Mapped hit
  input wire iols_event_t   bus_event_i,    // Bus events
  input wire logic [31:0]   io_addr_i,      // Address probe
  input wire logic          io_forward_o,   // Inside window
  input wire logic [31:0]   io_window_top_o // Window top
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic rd_top;  // Read of window top
  logic rd_slo;  // Read of status low byte
  logic rd_shi;  // Read of status high byte
  logic wr_shi;  // Write of status high byte
  logic par_any; // Any parity source
  // Decoded enabled accesses
  assign rd_top = ce_i && cfg_req_i.rd && cfg_req_i.addr == 8'h1d;
  assign rd_slo = ce_i && cfg_req_i.rd && cfg_req_i.addr == 8'h1e;
  assign rd_shi = ce_i && cfg_req_i.rd && cfg_req_i.addr == 8'h1f;
  assign wr_shi = ce_i && cfg_req_i.wr && cfg_req_i.addr == 8'h1f;
  assign par_any = bus_event_i.addr_attr_error |
                   bus_event_i.write_data_error |
                   bus_event_i.read_data_error;
  AST_TOP_CODE: assert property (rd_top |=>
    cfg_hit_o && cfg_rdata_o[3:0] == 4'h1)
    else $error("window top low nibble wrong");
  AST_TOP_FIELD: assert property (rd_top && !cfg_req_i.wr |=>
    cfg_rdata_o[7:4] == io_window_top_o[15:12])
    else $error("window top field mismatch");
  AST_TOP_FILL: assert property (io_window_top_o[11:0] == 12'hfff)
    else $error("window top low bits not all ones");
  AST_LO_FIXED: assert property (rd_slo |=>
    (cfg_rdata_o & 8'hdf) == 8'h80)
    else $error("status low byte fixed bits wrong");
  AST_HI_FIXED: assert property (rd_shi |=> cfg_rdata_o[3:0] == 4'h2)
    else $error("decode speed bits wrong");
  AST_PAR_SET: assert property (ce_i && par_any ##1 rd_shi
    |=> cfg_rdata_o[7])
    else $error("parity fault not recorded");
  AST_SYS_SET: assert property (ce_i && bus_event_i.system_error
    ##1 rd_shi |=> cfg_rdata_o[6])
    else $error("system fault not recorded");
  AST_MAB_SET: assert property (ce_i && bus_event_i.master_abort
    ##1 rd_shi |=> cfg_rdata_o[5])
    else $error("master abort not recorded");
  AST_TAB_SET: assert property (ce_i && bus_event_i.target_abort
    ##1 rd_shi |=> cfg_rdata_o[4])
    else $error("target abort not recorded");
  // Clear, one quiet cycle, then the read the bench makes
  AST_W1C: assert property (wr_shi && cfg_req_i.wdata[6] &&
    !cfg_req_i.rd && !bus_event_i.system_error
    ##1 !bus_event_i.system_error ##1 rd_shi |=> !cfg_rdata_o[6])
    else $error("write one did not clear");
  AST_ABOVE_TOP: assert property (ce_i && io_addr_i > io_window_top_o
    |=> !io_forward_o)
    else $error("forward above window top");
  cover property (rd_top);
  cover property (ce_i && bus_event_i.system_error ##1 rd_shi);
  cover property (wr_shi && cfg_req_i.wdata[5]);
endmodule
`default_nettype wire

// >>> sim/iols_bus_agent.sv
// Secondary bus agent model: raises error events, straps the pin.
// Assumes the bench asks for events one cycle ahead.
`timescale 1ns/1ps
`default_nettype none
module iols_bus_agent
  import iols_pkg::*;
(
  input  wire logic        sys_clk_i,       // Clock
  input  wire logic        strap_i,         // Strap level of the pin
  input  wire logic        fire_i,          // Raise events
  input  wire iols_event_t kind_i,          // Which events
  output var iols_event_t  bus_event_o,     // Event pulses
  output logic             fast_clock_pin_o // Strapped pin
);
  // Strap follows the bench, changed only by the pin scenario
  assign fast_clock_pin_o = strap_i;
  always_ff @(posedge sys_clk_i)
    bus_event_o <= fire_i ? kind_i : '0;
endmodule
`default_nettype wire

// >>> sim/iols_regs_test.sv
// Self-checking bench for the window top and bus status block.
// Assumes a 40 MHz clock and the bus agent model.
`timescale 1ns/1ps
`default_nettype none
module iols_regs_test
  import iols_pkg::*;
;
  logic clk, rst, hit, fire, pre, pin, fwd, ce, strap;
  iols_cfg_req_t req;
  iols_event_t   ev, kind;
  logic [7:0]    rdata;
  logic [31:0]   addr, top;
  int            fails, samples_checked;
  logic [5:0] evk [6] = '{6'h20, 6'h10, 6'h08, 6'h04, 6'h02, 6'h01};
  logic [7:0] evm [6] = '{8'h80, 8'h80, 8'h80, 8'h40, 8'h20, 8'h10};
  iols_regs u_dut (.sys_clk_i(clk), .rst_i(rst), .ce_i(ce),
    .cfg_req_i(req), .cfg_rdata_o(rdata), .cfg_hit_o(hit),
    .bus_event_i(ev), .parity_response_enable_i(pre),
    .fast_clock_pin_i(pin), .io_addr_i(addr), .io_forward_o(fwd),
    .io_window_top_o(top));
  iols_bus_agent u_agent (.sys_clk_i(clk), .strap_i(strap), .fire_i(fire),
    .kind_i(kind), .bus_event_o(ev), .fast_clock_pin_o(pin));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // One access, held over exactly one taking edge
  task automatic cfg(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    req = '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clk) #1;
    req = '0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    cfg(1'b0, a, 8'h00);
    check(rdata, e);
  endtask
  task automatic pulse(input logic [5:0] k);
    @(posedge clk) #1;
    kind = k;
    fire = 1'b1;
    @(posedge clk) #1;
    fire = 1'b0;
  endtask
  task automatic t_reset;
    rd_chk(8'h1d, 8'h01);
    check(hit, 1'b1);
    rd_chk(8'h1e, 8'ha0);
    rd_chk(8'h1f, 8'h02);
    check(top, 32'h00000fff);
  endtask
  // Window bounds probed on both sides of each edge
  task automatic t_window;
    logic [31:0] pa [4] = '{32'h12344fff, 32'h12345000,
                            32'h1234afff, 32'h1234b000};
    cfg(1'b1, 8'h1d, 8'hab);
    rd_chk(8'h1d, 8'ha1);
    cfg(1'b1, 8'h32, 8'h34);
    cfg(1'b1, 8'h33, 8'h12);
    check(top, 32'h1234afff);
    cfg(1'b1, 8'h1c, 8'h50);
    cfg(1'b1, 8'h30, 8'h34);
    cfg(1'b1, 8'h31, 8'h12);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk) #1;
      addr = pa[i];
      @(posedge clk) #1;
      check(fwd, i == 1 || i == 2);
    end
    rd_chk(8'h40, 8'h00);
    check(hit, 1'b0);
  endtask
  // Every event kind set, kept by zero writes, cleared by one
  task automatic t_events;
    for (int i = 0; i < 6; i++)
    begin
      pre = i[0];
      pulse(evk[i]);
      rd_chk(8'h1f, evm[i] | 8'h02);
      cfg(1'b1, 8'h1f, ~evm[i]);
      rd_chk(8'h1f, evm[i] | 8'h02);
      cfg(1'b1, 8'h1f, evm[i]);
      rd_chk(8'h1f, 8'h02);
    end
  endtask
  // Event at the clearing edge must win
  task automatic t_race;
    pulse(6'h02);
    req = '{rd: 1'b0, wr: 1'b1, addr: 8'h1f, wdata: 8'h20};
    @(posedge clk) #1;
    req = '0;
    rd_chk(8'h1f, 8'h22);
  endtask
  // Enable low: a write and an event are both ignored
  task automatic t_freeze;
    ce = 1'b0;
    pulse(6'h04);
    cfg(1'b1, 8'h1d, 8'h70);
    ce = 1'b1;
    rd_chk(8'h1d, 8'ha1);
    rd_chk(8'h1f, 8'h22);
  endtask
  // Bit 5 tracks the pin both ways once the filter settles
  task automatic t_pin;
    strap = 1'b0;
    repeat (6) @(posedge clk);
    rd_chk(8'h1e, 8'h80);
    strap = 1'b1;
    repeat (6) @(posedge clk);
    rd_chk(8'h1e, 8'ha0);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    rst = 1'b1;
    req = '0;
    kind = '0;
    fire = 1'b0;
    pre = 1'b0;
    addr = '0;
    ce = 1'b1;
    strap = 1'b1;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    repeat (6) @(posedge clk);
    t_reset;
    t_window;
    t_events;
    t_race;
    t_freeze;
    t_pin;
    test_done;
  end
  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (3000) @(posedge clk);
    fails++;
    test_done;
  end
endmodule
bind iols_regs iols_regs_props u_props (.sys_clk_i(sys_clk_i),
  .rst_i(rst_i), .ce_i(ce_i), .cfg_req_i(cfg_req_i),
  .cfg_rdata_o(cfg_rdata_o), .cfg_hit_o(cfg_hit_o),
  .bus_event_i(bus_event_i), .io_addr_i(io_addr_i),
  .io_forward_o(io_forward_o), .io_window_top_o(io_window_top_o));
`default_nettype wire
